// ==== inc/swc_pkg.sv ====
package swc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0]  CMD_OFS        = 4'h0;
   localparam logic [3:0]  CFG_OFS        = 4'h4;
   localparam logic [3:0]  STAT_OFS       = 4'h8;
   localparam logic [3:0]  IMASK_OFS      = 4'hC;

   // control word fields
   localparam int          KEY_LSB        = 24;
   localparam logic [7:0]  KEY_VALUE      = 8'hA5;
   localparam int          CMD_OFF_BIT    = 0;

   // configuration fields
   localparam int          EDGE_LSB       = 0;
   localparam int          DEB_LSB        = 4;
   localparam int          DEB_W          = 4;
   localparam int          IVL_EN_BIT     = 16;
   localparam int          CAL_EN_BIT     = 17;
   localparam logic [31:0] CFG_RESET      = 32'h0000_0003;

   // status fields
   localparam int          ST_PIN_BIT     = 0;
   localparam int          ST_IVL_BIT     = 16;
   localparam int          ST_CAL_BIT     = 17;

   // timing
   localparam int          DEB_UNIT       = 16;
   localparam int          CMD_DELAY      = 2;
   localparam int          CNT_W          = 8;

   // edge-select encodings
   localparam logic [1:0]  EDGE_NONE      = 2'h0;
   localparam logic [1:0]  EDGE_RISE      = 2'h1;
   localparam logic [1:0]  EDGE_FALL      = 2'h2;
   localparam logic [1:0]  EDGE_ANY       = 2'h3;

   // wake-pin debounce states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_COUNT = 2'b10
   } swc_deb_t;

   // wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } swc_wb_req_t;

   // whole state of the controller
   typedef struct packed {
      logic        ack;
      logic [31:0] rdat;
      logic [1:0]  edge_sel;
      logic [3:0]  deb_cnt;
      logic        ivl_en;
      logic        cal_en;
      logic [2:0]  stat;
      logic [2:0]  imask;
      logic [1:0]  cmd_pipe;
      logic        off;
      logic [1:0]  wk_sync;
      logic        wk_last;
      logic [1:0]  ivl_sync;
      logic        ivl_last;
      logic [1:0]  cal_sync;
      logic        cal_last;
      swc_deb_t    deb_st;
      logic [CNT_W-1:0] cnt;
   } swc_state_t;

endpackage

// ==== hdl/swc_controller.sv ====
// Summary of operation
// - keyed write with command bit asserts power-off
// - power-off takes effect two cycles after write
// - wrong key discards the whole control write
// - wake input level change is a wake source
// - pulses under count times sixteen are rejected
// - debounce counter reaching target releases power-off
// - new change before target clears the counter
// - pin wake flag set, cleared by status read
// - interval alarm rising edge wakes when enabled
// - interval alarm wake flagged, cleared by read
// - calendar alarm rising edge wakes when enabled
// - calendar alarm wake flagged, cleared by read
// - runs continuously on slow clock, never gated
// - edge select: off, rise, fall, any
// - release after count times sixteen plus one
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
module swc_controller (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // wishbone slave
   input  wire swc_pkg::swc_wb_req_t  wb_req,
   output logic                       wb_ack,
   output logic [31:0]                wb_rdat,
   // pins and alarms
   input  wire logic                  wake_in,
   input  wire logic                  interval_alarm,
   input  wire logic                  calendar_alarm,
   output logic                       power_off_out,
   // interrupt
   output logic                       irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   swc_pkg::swc_state_t s_reg;
   swc_pkg::swc_state_t s_next;

   localparam int CNT_W_L = swc_pkg::CNT_W;

   logic                acc;
   logic                wr;
   logic                rd;
   logic                key_ok;
   logic                wk_edge;
   logic                wk_sel;
   logic                ivl_ev;
   logic                cal_ev;
   logic                pin_ev;
   logic [CNT_W_L-1:0]  target;
   logic [2:0]          ev;
   logic [2:0]          clr;
   logic                keyed_wr;
   logic                stat_rd;

   // ------------------------------------------------------------
   // bus decode and event detection
   // ------------------------------------------------------------
   // single-cycle answer; ack drops after one cycle and a held request is not re-taken while ack is high
   assign acc    = wb_req.cyc && wb_req.stb && !s_reg.ack;
   assign wr     = acc && wb_req.we;
   assign rd     = acc && !wb_req.we;
   assign key_ok = wb_req.dat[swc_pkg::KEY_LSB +: 8] == swc_pkg::KEY_VALUE;
   // edge detectors look at the second synchroniser stage only
   assign wk_edge = s_reg.wk_sync[1] != s_reg.wk_last;
   assign ivl_ev = s_reg.ivl_en && s_reg.ivl_sync[1] && !s_reg.ivl_last;
   assign cal_ev = s_reg.cal_en && s_reg.cal_sync[1] && !s_reg.cal_last;
   assign target = CNT_W_L'(s_reg.deb_cnt) * CNT_W_L'(swc_pkg::DEB_UNIT);

   // decode the edge-select field
   always_comb begin
      unique case (s_reg.edge_sel)
         swc_pkg::EDGE_NONE: wk_sel = 1'b0;
         swc_pkg::EDGE_RISE: wk_sel = wk_edge && s_reg.wk_sync[1];
         swc_pkg::EDGE_FALL: wk_sel = wk_edge && !s_reg.wk_sync[1];
         swc_pkg::EDGE_ANY:  wk_sel = wk_edge;
      endcase
   end

   // pin wake fires once the filtered level has stood long enough
   assign pin_ev = (s_reg.deb_st == swc_pkg::ST_COUNT) && !wk_edge
                   && (s_reg.cnt >= target);
   assign ev     = {cal_ev, ivl_ev, pin_ev};
   assign clr    = (wr && wb_req.adr == swc_pkg::STAT_OFS) ? wb_req.dat[2:0] : 3'h0;
   // qualified strobes, kept as plain signals so checks can combine them freely
   assign keyed_wr = wr && wb_req.adr == swc_pkg::CMD_OFS && key_ok
                     && wb_req.dat[swc_pkg::CMD_OFF_BIT];
   assign stat_rd  = rd && wb_req.adr == swc_pkg::STAT_OFS;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.ack      = acc;
      s_next.wk_sync  = {s_reg.wk_sync[0], wake_in};
      s_next.wk_last  = s_reg.wk_sync[1];
      s_next.ivl_sync = {s_reg.ivl_sync[0], interval_alarm};
      s_next.ivl_last = s_reg.ivl_sync[1];
      s_next.cal_sync = {s_reg.cal_sync[0], calendar_alarm};
      s_next.cal_last = s_reg.cal_sync[1];
      s_next.cmd_pipe = {s_reg.cmd_pipe[0], 1'b0};

      // debounce: start on selected change, clear on any further change
      unique case (s_reg.deb_st)
         swc_pkg::ST_IDLE: begin
            s_next.cnt = '0;
            if (wk_sel) begin
               s_next.deb_st = swc_pkg::ST_COUNT;
            end
         end
         swc_pkg::ST_COUNT: begin
            if (wk_edge) begin
               s_next.cnt    = '0;
               s_next.deb_st = wk_sel ? swc_pkg::ST_COUNT : swc_pkg::ST_IDLE;
            end else if (pin_ev) begin
               s_next.cnt    = '0;
               s_next.deb_st = swc_pkg::ST_IDLE;
            end else begin
               s_next.cnt = s_reg.cnt + CNT_W_L'(1);
            end
         end
         default: begin
            s_next.deb_st = swc_pkg::ST_IDLE;
            s_next.cnt    = '0;
         end
      endcase

      // read data, status read clears flags
      s_next.rdat = '0;
      if (rd) begin
         unique case (wb_req.adr)
            swc_pkg::CFG_OFS: begin
               s_next.rdat[swc_pkg::EDGE_LSB +: 2]             = s_reg.edge_sel;
               s_next.rdat[swc_pkg::DEB_LSB +: swc_pkg::DEB_W] = s_reg.deb_cnt;
               s_next.rdat[swc_pkg::IVL_EN_BIT]                = s_reg.ivl_en;
               s_next.rdat[swc_pkg::CAL_EN_BIT]                = s_reg.cal_en;
            end
            swc_pkg::STAT_OFS: begin
               s_next.rdat[swc_pkg::ST_PIN_BIT] = s_reg.stat[0];
               s_next.rdat[swc_pkg::ST_IVL_BIT] = s_reg.stat[1];
               s_next.rdat[swc_pkg::ST_CAL_BIT] = s_reg.stat[2];
               s_next.stat = 3'h0;
            end
            swc_pkg::IMASK_OFS: s_next.rdat[2:0] = s_reg.imask;
            default: s_next.rdat = '0;
         endcase
      end

      // writes; command word only counts with the right key
      if (wr) begin
         unique case (wb_req.adr)
            swc_pkg::CMD_OFS: begin
               if (key_ok && wb_req.dat[swc_pkg::CMD_OFF_BIT]) begin
                  s_next.cmd_pipe[0] = 1'b1;
               end
            end
            swc_pkg::CFG_OFS: begin
               s_next.edge_sel = wb_req.dat[swc_pkg::EDGE_LSB +: 2];
               s_next.deb_cnt  = wb_req.dat[swc_pkg::DEB_LSB +: swc_pkg::DEB_W];
               s_next.ivl_en   = wb_req.dat[swc_pkg::IVL_EN_BIT];
               s_next.cal_en   = wb_req.dat[swc_pkg::CAL_EN_BIT];
            end
            swc_pkg::IMASK_OFS: s_next.imask = wb_req.dat[2:0];
            default: s_next.imask = s_reg.imask;
         endcase
      end
      // status flags clear by writing ones; set beats both clears
      s_next.stat = (s_next.stat & ~clr) | ev;

      // power-off output: command two cycles late, any wake releases it
      if (|ev) begin
         s_next.off = 1'b0;
      end else if (s_reg.cmd_pipe[1]) begin
         s_next.off = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers: free-running on the slow clock, no enable
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg          <= '0;
         s_reg.edge_sel <= swc_pkg::CFG_RESET[1:0];
         s_reg.deb_st   <= swc_pkg::ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs
   assign wb_ack        = s_reg.ack;
   assign wb_rdat       = s_reg.rdat;
   assign power_off_out = s_reg.off;
   assign irq           = |(s_reg.stat & s_reg.imask);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence keyed_cmd;
      keyed_wr;
   endsequence

   // accepted command and no wake in the cycle that loads the output
   sequence cmd_ripe;
      keyed_cmd ##2 !(|ev);
   endsequence

   // selected change seen while the debounce is idle
   sequence wake_seen;
      s_reg.deb_st == swc_pkg::ST_IDLE && wk_sel;
   endsequence

   // ------------------------------------------------------------
   // checks: command path, wake sources and status flags
   // ------------------------------------------------------------
   a_cmd_delay: assert property (@(posedge clk) disable iff (reset)
      cmd_ripe |=> power_off_out)
      else $error("power-off not asserted two cycles after command");
   a_cmd_early: assert property (@(posedge clk) disable iff (reset)
      keyed_wr && !power_off_out |=> !power_off_out)
      else $error("power-off asserted too early");
   a_cmd_pipe: assert property (@(posedge clk) disable iff (reset)
      keyed_cmd |=> s_reg.cmd_pipe[0])
      else $error("keyed command not taken");
   a_off_source: assert property (@(posedge clk) disable iff (reset)
      $rose(power_off_out) |-> $past(s_reg.cmd_pipe[1]))
      else $error("power-off rose without a delayed command");
   a_off_hold: assert property (@(posedge clk) disable iff (reset)
      power_off_out && !(|ev) |=> power_off_out)
      else $error("power-off dropped without a wake");
   a_bad_key: assert property (@(posedge clk) disable iff (reset)
      wr && wb_req.adr == swc_pkg::CMD_OFS && !key_ok |=> !s_reg.cmd_pipe[0])
      else $error("command taken with wrong key");
   a_wake_release: assert property (@(posedge clk) disable iff (reset)
      |ev |=> !power_off_out)
      else $error("wake did not release power-off");
   a_edge_none: assert property (@(posedge clk) disable iff (reset)
      s_reg.edge_sel == swc_pkg::EDGE_NONE && s_reg.deb_st == swc_pkg::ST_IDLE
      |=> s_reg.deb_st == swc_pkg::ST_IDLE)
      else $error("detection ran while disabled");
   a_deb_clear: assert property (@(posedge clk) disable iff (reset)
      s_reg.deb_st == swc_pkg::ST_COUNT && wk_edge |=> s_reg.cnt == '0)
      else $error("counter not cleared by new change");
   a_pin_flag: assert property (@(posedge clk) disable iff (reset)
      pin_ev |=> s_reg.stat[0])
      else $error("pin wake flag not set");
   a_ivl_flag: assert property (@(posedge clk) disable iff (reset)
      ivl_ev |=> s_reg.stat[1])
      else $error("interval wake flag not set");
   a_cal_flag: assert property (@(posedge clk) disable iff (reset)
      cal_ev |=> s_reg.stat[2])
      else $error("calendar wake flag not set");
   a_read_clear: assert property (@(posedge clk) disable iff (reset)
      rd && wb_req.adr == swc_pkg::STAT_OFS && !(|ev) |=> s_reg.stat == 3'h0)
      else $error("status read did not clear");
   a_ivl_gate: assert property (@(posedge clk) disable iff (reset)
      !s_reg.ivl_en |-> !ivl_ev)
      else $error("interval wake while disabled");
   a_cal_gate: assert property (@(posedge clk) disable iff (reset)
      !s_reg.cal_en |-> !cal_ev)
      else $error("calendar wake while disabled");
   a_deb_min: assert property (@(posedge clk) disable iff (reset)
      pin_ev |-> s_reg.cnt >= target)
      else $error("pin wake before debounce time");

   // ------------------------------------------------------------
   // checks: wake pin
   // ------------------------------------------------------------
   // each edge code lets through only its own direction
   a_edge_rise: assert property (@(posedge clk) disable iff (reset)
      s_reg.edge_sel == swc_pkg::EDGE_RISE && wk_edge && !s_reg.wk_sync[1] |-> !wk_sel)
      else $error("falling change taken in rise mode");
   a_edge_fall: assert property (@(posedge clk) disable iff (reset)
      s_reg.edge_sel == swc_pkg::EDGE_FALL && wk_edge && s_reg.wk_sync[1] |-> !wk_sel)
      else $error("rising change taken in fall mode");
   a_edge_any: assert property (@(posedge clk) disable iff (reset)
      s_reg.edge_sel == swc_pkg::EDGE_ANY |-> wk_sel == wk_edge)
      else $error("change missed in any-change mode");
   a_deb_start: assert property (@(posedge clk) disable iff (reset)
      wake_seen |=> s_reg.deb_st == swc_pkg::ST_COUNT && s_reg.cnt == '0)
      else $error("debounce did not start from zero");
   // counting steps by one while the level stands
   a_deb_count: assert property (@(posedge clk) disable iff (reset)
      s_reg.deb_st == swc_pkg::ST_COUNT && !wk_edge && !pin_ev
      |=> s_reg.cnt == $past(s_reg.cnt) + 8'h01)
      else $error("debounce counter skipped");
   a_deb_drop: assert property (@(posedge clk) disable iff (reset)
      s_reg.deb_st == swc_pkg::ST_COUNT && wk_edge && !wk_sel
      |=> s_reg.deb_st == swc_pkg::ST_IDLE)
      else $error("unselected change kept counting");
   a_idle_cnt: assert property (@(posedge clk) disable iff (reset)
      s_reg.deb_st == swc_pkg::ST_IDLE |-> s_reg.cnt == '0)
      else $error("counter left over while idle");
   a_pin_release: assert property (@(posedge clk) disable iff (reset)
      pin_ev |=> !power_off_out)
      else $error("pin wake did not release power-off");

   // ------------------------------------------------------------
   // checks: alarms, status and configuration read
   // ------------------------------------------------------------
   a_ivl_release: assert property (@(posedge clk) disable iff (reset)
      ivl_ev |=> !power_off_out)
      else $error("interval wake did not release power-off");
   a_cal_release: assert property (@(posedge clk) disable iff (reset)
      cal_ev |=> !power_off_out)
      else $error("calendar wake did not release power-off");
   // flags are sticky until a read or a ones-write clears them
   a_stat_hold: assert property (@(posedge clk) disable iff (reset)
      !(|ev) && !stat_rd && clr == 3'h0 |=> s_reg.stat == $past(s_reg.stat))
      else $error("status flag changed on its own");
   a_set_wins: assert property (@(posedge clk) disable iff (reset)
      stat_rd && (|ev) |=> (s_reg.stat & $past(ev)) == $past(ev))
      else $error("event lost during status read");
   a_stat_wclr: assert property (@(posedge clk) disable iff (reset)
      !(|ev) && clr != 3'h0 |=> (s_reg.stat & $past(clr)) == 3'h0)
      else $error("status not cleared by ones-write");
   a_stat_data: assert property (@(posedge clk) disable iff (reset)
      stat_rd |=> wb_rdat[swc_pkg::ST_PIN_BIT] == $past(s_reg.stat[0]))
      else $error("status read returned stale pin flag");
   a_cfg_data: assert property (@(posedge clk) disable iff (reset)
      rd && wb_req.adr == swc_pkg::CFG_OFS |=> wb_rdat[1:0] == $past(s_reg.edge_sel))
      else $error("configuration read returned wrong edge code");

   // ------------------------------------------------------------
   // checks: bus
   // ------------------------------------------------------------
   // a held request must not be answered twice in a row
   a_ack_once: assert property (@(posedge clk) disable iff (reset)
      wb_ack |=> !wb_ack)
      else $error("acknowledge longer than one cycle");
   a_ack_follow: assert property (@(posedge clk) disable iff (reset)
      acc |=> wb_ack)
      else $error("taken request not acknowledged");
   a_wr_rdat: assert property (@(posedge clk) disable iff (reset)
      wb_ack && $past(wr) |-> wb_rdat == '0)
      else $error("write answered with nonzero data");

endmodule

// ==== verif/swc_partner.sv ====
`timescale 1ns/10ps
module swc_partner (
   // slow clock
   input  wire logic clk,
   // converter side
   input  wire logic power_off_out,
   output logic      supply_up,
   // push-button side
   input  wire logic press,
   output logic      wake_in
);
   // converter output follows shutdown one cycle late; no soft-start modelled
   always_ff @(posedge clk) begin
      supply_up <= ~power_off_out;
   end
   // button is bounce-free; the bench shapes the pulses itself
   assign wake_in = press;
endmodule

// ==== verif/shutdown_wake_controller_bench.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module shutdown_wake_controller_bench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                 clk, reset, pr, wk, ia, ca, ack, off, irq, sup;
   swc_pkg::swc_wb_req_t req;
   logic [31:0]          rd, rng, ex;
   logic [31:0]          exp_q[$];
   int                   bad_count, tests_run, n;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   swc_controller uut (.clk(clk), .reset(reset), .wb_req(req), .wb_ack(ack),
      .wb_rdat(rd), .wake_in(wk), .interval_alarm(ia), .calendar_alarm(ca),
      .power_off_out(off), .irq(irq));
   swc_partner bud (.clk(clk), .power_off_out(off), .supply_up(sup), .press(pr),
      .wake_in(wk));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // one classic cycle; the expected answer is queued for the monitor
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask

   task automatic cmd(input logic [7:0] key);
      xfer(1'b1, swc_pkg::CMD_OFS, {key, 24'h00_0001}, 32'h0000_0000);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // monitor: every ack retires the oldest queued expectation
   always @(posedge clk) begin
      if (ack === 1'b1) begin
         if (exp_q.size() == 0) `CHK("queue", 1'b1, 1'b0)
         else begin
            ex = exp_q.pop_front();
            `CHK("rdat", ex, rd)
         end
      end
   end

   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      summarize;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      req = '0;
      pr = 1'b0;
      ia = 1'b0;
      ca = 1'b0;
      reset = 1'b1;
      bad_count = 0;
      tests_run = 0;
      rng = 32'h10B0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      // reset values and write-only readback
      xfer(1'b0, swc_pkg::CFG_OFS, 32'h0, swc_pkg::CFG_RESET);
      xfer(1'b0, swc_pkg::STAT_OFS, 32'h0, 32'h0);
      xfer(1'b0, swc_pkg::CMD_OFS, 32'h0, 32'h0);
      // random mask values read back, only three bits live
      for (int i = 0; i < 4; i++) begin
         rng = lfsr(rng);
         xfer(1'b1, swc_pkg::IMASK_OFS, rng, 32'h0);
         xfer(1'b0, swc_pkg::IMASK_OFS, 32'h0, {29'h0, rng[2:0]});
      end
      // rising edge, debounce one unit, pin interrupt unmasked
      xfer(1'b1, swc_pkg::CFG_OFS, 32'h0000_0011, 32'h0);
      xfer(1'b1, swc_pkg::IMASK_OFS, 32'h0000_0001, 32'h0);
      cmd(8'h5A);
      repeat (3) @(posedge clk);
      #1 `CHK("off", 1'b0, off)
      // output still low at the ack edge, high at the edge on which the task returns
      fork
         cmd(swc_pkg::KEY_VALUE);
         begin
            repeat (3) @(posedge clk);
            #1 `CHK("off", 1'b0, off)
         end
      join
      #1 `CHK("off", 1'b1, off)
      // short pulse must not wake
      @(posedge clk);
      pr <= 1'b1;
      repeat (8) @(posedge clk);
      pr <= 1'b0;
      repeat (40) @(posedge clk);
      #1 `CHK("off", 1'b1, off)
      // held press releases after one debounce unit plus sync
      @(posedge clk);
      pr <= 1'b1;
      n = 0;
      while (off === 1'b1 && n < 60) begin
         @(posedge clk);
         #1 n++;
      end
      `CHK("release", 1'b1, (n >= 17 && n <= 21))
      @(posedge clk);
      #1 `CHK("supply", 1'b1, sup)
      `CHK("irq", 1'b1, irq)
      xfer(1'b0, swc_pkg::STAT_OFS, 32'h0, 32'h0000_0001);
      #1 `CHK("irq", 1'b0, irq)
      pr <= 1'b0;
      xfer(1'b0, swc_pkg::STAT_OFS, 32'h0, 32'h0);
      // every edge mode, debounce zero
      for (int m = 0; m < 4; m++) begin
         xfer(1'b1, swc_pkg::CFG_OFS, 32'(m), 32'h0);
         cmd(swc_pkg::KEY_VALUE);
         pr <= 1'b1;
         repeat (8) @(posedge clk);
         xfer(1'b0, swc_pkg::STAT_OFS, 32'h0, {31'h0, m[0]});
         pr <= 1'b0;
         repeat (8) @(posedge clk);
         xfer(1'b0, swc_pkg::STAT_OFS, 32'h0, {31'h0, m[1]});
      end
      // one alarm enabled, both rise: only the enabled one wakes and flags
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, swc_pkg::CFG_OFS, 32'h1 << (16 + k), 32'h0);
         cmd(swc_pkg::KEY_VALUE);
         repeat (3) @(posedge clk);
         ia <= 1'b1;
         ca <= 1'b1;
         repeat (8) @(posedge clk);
         #1 `CHK("off", 1'b0, off)
         xfer(1'b0, swc_pkg::STAT_OFS, 32'h0, 32'h1 << (16 + k));
         ia <= 1'b0;
         ca <= 1'b0;
         repeat (4) @(posedge clk);
      end
      summarize;
   end
endmodule
